/* File: core/icch_pkg.sv */
// Purpose: shared constants and types of the input counter command handler
// Assumes: eight input channels, 16-bit counters, 25 MHz clock
// Notes: command codes and field positions live here only

package icch_pkg;

  // ****************************************************************
  // sizes and field positions
  // ****************************************************************
  localparam int NUM_CH = 8;
  localparam int CNT_W = 16;
  localparam int BYTE_W = 8;
  localparam int CH_SEL_W = 3;
  localparam int CH_SEL_LSB = 0;

  // ****************************************************************
  // command codes
  // ****************************************************************
  localparam logic [7:0] CMD_RISE_EN = 8'h23;
  localparam logic [7:0] CMD_FALL_EN = 8'h24;
  localparam logic [7:0] CMD_CNT_EN = 8'h28;
  localparam logic [7:0] CMD_CNT_RST = 8'h29;
  localparam logic [7:0] CMD_OVF_IE = 8'h2a;
  localparam logic [7:0] CMD_MATCH_IE = 8'h2b;
  localparam logic [7:0] CMD_CNT_EDGE = 8'h2c;
  localparam logic [7:0] CMD_CNT_READ = 8'h2f;
  localparam logic [7:0] CMD_HIGH_FIRST = 8'h30;
  localparam logic [7:0] CMD_HIGH_LAST = 8'h37;
  localparam logic [7:0] CMD_LOW_FIRST = 8'h38;
  localparam logic [7:0] CMD_LOW_LAST = 8'h3f;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [15:0] SAMPLE_RESET = 16'h0000;
  localparam logic [15:0] CNT_MAX = 16'hffff;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam int CLK_HZ = 25_000_000;
  localparam int MS_PER_S = 1000;
  localparam int SAMPLE_MS = 5;
  localparam int SAMPLE_CYCLES = CLK_HZ / MS_PER_S * SAMPLE_MS;

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum {ST_IDLE, ST_EXEC, ST_REPLY} icch_state_t;

  typedef struct packed {
    logic [7:0] out_mailbox_byte3;
    logic [7:0] out_mailbox_byte2;
    logic [7:0] out_mailbox_byte1;
    logic [7:0] out_mailbox_byte0;
  } icch_out_mbox_t;

  typedef struct packed {
    logic [7:0] in_mailbox_byte3;
    logic [7:0] in_mailbox_byte2;
    logic [7:0] in_mailbox_byte1;
    logic [7:0] in_mailbox_byte0;
  } icch_in_mbox_t;

  typedef logic [NUM_CH-1:0][CNT_W-1:0] icch_word_vec_t;

endpackage : icch_pkg

/* File: core/icch_input_counter_cmd.sv */
// Purpose: command handler for eight filtered inputs with edge counters
// Assumes: host writes a whole command then raises cmd_valid once
// Notes: one command in flight; reply_valid marks completion
// Operation
// - reply echoes command code in byte 2, input levels in byte 3
// - code 23 loads rising-edge detection enables from byte 0
// - code 24 loads falling-edge detection enables from byte 0
// - enabled detected transition raises interrupt request
// - code 28 loads counter enable mask from byte 0
// - code 29 reloads selected counters with their reset value
// - code 2A sets overflow interrupt enables; gate overflow irq
// - code 2B sets match interrupt enables from byte 0
// - code 2C picks counting edge: one falling, zero rising
// - readback returns count high byte in byte 1, low in byte 0
// - sampling number is byte 1 times 256 plus byte 0
// - qualification period equals sampling number times 5 ms
// - codes 30-37 set high numbers, 38-3F low numbers
// - filtered level shorter than its period is ignored
// - each channel has its own 16-bit counter reset value
// - overflow and match flags kept as two 8-bit masks
`timescale 1ns/1ps
`default_nettype none

module icch_input_counter_cmd #(
  parameter int NUM_CH = icch_pkg::NUM_CH,
  parameter int SAMPLE_CYCLES = icch_pkg::SAMPLE_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // host mailbox
  input wire icch_pkg::icch_out_mbox_t out_mailbox,
  input wire logic cmd_valid,
  output logic cmd_ready,
  output icch_pkg::icch_in_mbox_t in_mailbox,
  output logic reply_valid,
  // inputs and plain configuration
  input wire logic [NUM_CH-1:0] isolated_input_channel,
  input wire logic [NUM_CH-1:0] filter_enable,
  input wire icch_pkg::icch_word_vec_t reset_value,
  input wire icch_pkg::icch_word_vec_t match_value,
  // flag clears, one bit per channel
  input wire logic [NUM_CH-1:0] edge_clear,
  input wire logic [NUM_CH-1:0] overflow_clear,
  input wire logic [NUM_CH-1:0] match_clear,
  // status
  output logic [NUM_CH-1:0] channel_state,
  output logic [NUM_CH-1:0] rise_flags,
  output logic [NUM_CH-1:0] fall_flags,
  output logic [NUM_CH-1:0] overflow_flags,
  output logic [NUM_CH-1:0] match_flags,
  output logic irq
);

  localparam int TICK_W = $clog2(SAMPLE_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(SAMPLE_CYCLES - 1);
  localparam logic [TICK_W-1:0] TICK_ZERO = '0;

  if (NUM_CH != icch_pkg::NUM_CH || SAMPLE_CYCLES < 1) begin : g_check
    $error("unsupported channel count or sample interval");
  end

  // sampling commands: index selects channel, bit 3 selects low
  function automatic logic is_sample(input logic [7:0] code);
    is_sample = code >= icch_pkg::CMD_HIGH_FIRST &&
                code <= icch_pkg::CMD_LOW_LAST;
  endfunction : is_sample

  // ****************************************************************
  // command sequencer
  // ****************************************************************
  icch_pkg::icch_state_t state, next_state;
  icch_pkg::icch_out_mbox_t cmd, next_cmd;
  logic [NUM_CH-1:0] rise_en, next_rise_en, fall_en, next_fall_en;
  logic [NUM_CH-1:0] cnt_en, next_cnt_en, cnt_edge, next_cnt_edge;
  logic [NUM_CH-1:0] ovf_ie, next_ovf_ie, match_ie, next_match_ie;
  icch_pkg::icch_word_vec_t high_num, next_high_num;
  icch_pkg::icch_word_vec_t low_num, next_low_num;
  icch_pkg::icch_in_mbox_t next_in_mailbox;
  logic next_reply_valid;
  logic [NUM_CH-1:0] cnt_rst_mask;
  logic [icch_pkg::CH_SEL_W-1:0] read_sel;
  logic [icch_pkg::CNT_W-1:0] param_word;
  icch_pkg::icch_word_vec_t count;

  assign cmd_ready = state == icch_pkg::ST_IDLE;
  // upper bits ignored; host keeps them zero
  assign read_sel = cmd.out_mailbox_byte0[icch_pkg::CH_SEL_LSB +:
                                          icch_pkg::CH_SEL_W];
  assign param_word = {cmd.out_mailbox_byte1, cmd.out_mailbox_byte0};
  assign cnt_rst_mask = (state == icch_pkg::ST_EXEC &&
      cmd.out_mailbox_byte2 == icch_pkg::CMD_CNT_RST) ?
      cmd.out_mailbox_byte0 : icch_pkg::MASK_RESET;

  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_rise_en = rise_en;
    next_fall_en = fall_en;
    next_cnt_en = cnt_en;
    next_cnt_edge = cnt_edge;
    next_ovf_ie = ovf_ie;
    next_match_ie = match_ie;
    next_high_num = high_num;
    next_low_num = low_num;
    next_in_mailbox = in_mailbox;
    next_reply_valid = 1'b0;
    case (state)
      icch_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          next_cmd = out_mailbox;
          next_state = icch_pkg::ST_EXEC;
        end
      end
      icch_pkg::ST_EXEC: begin
        // unknown codes change nothing but are still echoed
        case (cmd.out_mailbox_byte2)
          icch_pkg::CMD_RISE_EN: next_rise_en = cmd.out_mailbox_byte0;
          icch_pkg::CMD_FALL_EN: next_fall_en = cmd.out_mailbox_byte0;
          icch_pkg::CMD_CNT_EN: next_cnt_en = cmd.out_mailbox_byte0;
          icch_pkg::CMD_OVF_IE: next_ovf_ie = cmd.out_mailbox_byte0;
          icch_pkg::CMD_MATCH_IE: next_match_ie = cmd.out_mailbox_byte0;
          icch_pkg::CMD_CNT_EDGE: next_cnt_edge = cmd.out_mailbox_byte0;
          default: begin
            if (is_sample(cmd.out_mailbox_byte2)) begin
              if (cmd.out_mailbox_byte2 <= icch_pkg::CMD_HIGH_LAST) begin
                next_high_num[cmd.out_mailbox_byte2[2:0]] = param_word;
              end else begin
                next_low_num[cmd.out_mailbox_byte2[2:0]] = param_word;
              end
            end
          end
        endcase
        next_state = icch_pkg::ST_REPLY;
      end
      icch_pkg::ST_REPLY: begin
        // effects landed at the previous edge
        next_in_mailbox.in_mailbox_byte3 = channel_state;
        next_in_mailbox.in_mailbox_byte2 = cmd.out_mailbox_byte2;
        next_in_mailbox.in_mailbox_byte1 = 8'h00;
        next_in_mailbox.in_mailbox_byte0 = 8'h00;
        if (cmd.out_mailbox_byte2 == icch_pkg::CMD_CNT_READ) begin
          {next_in_mailbox.in_mailbox_byte1,
           next_in_mailbox.in_mailbox_byte0} = count[read_sel];
        end
        next_reply_valid = 1'b1;
        next_state = icch_pkg::ST_IDLE;
      end
      default: next_state = icch_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      state <= icch_pkg::ST_IDLE;
      cmd <= '0;
      rise_en <= icch_pkg::MASK_RESET;
      fall_en <= icch_pkg::MASK_RESET;
      cnt_en <= icch_pkg::MASK_RESET;
      cnt_edge <= icch_pkg::MASK_RESET;
      ovf_ie <= icch_pkg::MASK_RESET;
      match_ie <= icch_pkg::MASK_RESET;
      high_num <= {NUM_CH{icch_pkg::SAMPLE_RESET}};
      low_num <= {NUM_CH{icch_pkg::SAMPLE_RESET}};
      in_mailbox <= '0;
      reply_valid <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      rise_en <= next_rise_en;
      fall_en <= next_fall_en;
      cnt_en <= next_cnt_en;
      cnt_edge <= next_cnt_edge;
      ovf_ie <= next_ovf_ie;
      match_ie <= next_match_ie;
      high_num <= next_high_num;
      low_num <= next_low_num;
      in_mailbox <= next_in_mailbox;
      reply_valid <= next_reply_valid;
    end
  end

  // ****************************************************************
  // filters, counters and flags
  // ****************************************************************
  logic [TICK_W-1:0] tick_cnt, next_tick_cnt;
  logic tick;
  icch_pkg::icch_word_vec_t deb_cnt, next_deb_cnt, next_count;
  logic [NUM_CH-1:0] next_channel_state, rise_ev, fall_ev, inc_ev;
  logic [NUM_CH-1:0] next_rise_flags, next_fall_flags;
  logic [NUM_CH-1:0] next_overflow_flags, next_match_flags;

  assign tick = tick_cnt == TICK_LAST;

  always_comb begin
    logic [icch_pkg::CNT_W-1:0] num;
    num = icch_pkg::SAMPLE_RESET;
    // free-running 5 ms tick: period accurate to one tick
    next_tick_cnt = tick ? TICK_ZERO : tick_cnt + 1'b1;
    next_channel_state = channel_state;
    next_deb_cnt = deb_cnt;
    next_count = count;
    for (int i = 0; i < NUM_CH; i++) begin
      num = isolated_input_channel[i] ? high_num[i] : low_num[i];
      if (!filter_enable[i] || isolated_input_channel[i] == channel_state[i])
      begin
        // short excursions drop their progress
        next_deb_cnt[i] = icch_pkg::SAMPLE_RESET;
        next_channel_state[i] = isolated_input_channel[i];
      end else if (num == icch_pkg::SAMPLE_RESET ||
                   (tick && deb_cnt[i] == num - icch_pkg::CNT_ONE)) begin
        next_deb_cnt[i] = icch_pkg::SAMPLE_RESET;
        next_channel_state[i] = isolated_input_channel[i];
      end else if (tick) begin
        next_deb_cnt[i] = deb_cnt[i] + icch_pkg::CNT_ONE;
      end
    end
    rise_ev = next_channel_state & ~channel_state;
    fall_ev = ~next_channel_state & channel_state;
    inc_ev = cnt_en & ((cnt_edge & fall_ev) | (~cnt_edge & rise_ev));
    for (int i = 0; i < NUM_CH; i++) begin
      if (cnt_rst_mask[i]) begin
        next_count[i] = reset_value[i];
      end else if (inc_ev[i]) begin
        next_count[i] = count[i] + icch_pkg::CNT_ONE;
      end
    end
    // a set in the clearing cycle wins
    next_rise_flags = (rise_flags & ~edge_clear) | (rise_ev & rise_en);
    next_fall_flags = (fall_flags & ~edge_clear) | (fall_ev & fall_en);
    next_overflow_flags = overflow_flags & ~overflow_clear;
    next_match_flags = match_flags & ~match_clear;
    for (int i = 0; i < NUM_CH; i++) begin
      if (!cnt_rst_mask[i] && inc_ev[i] && count[i] == icch_pkg::CNT_MAX) begin
        next_overflow_flags[i] = 1'b1;
      end
      if (!cnt_rst_mask[i] && inc_ev[i] && next_count[i] == match_value[i])
      begin
        next_match_flags[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      tick_cnt <= TICK_ZERO;
      deb_cnt <= {NUM_CH{icch_pkg::SAMPLE_RESET}};
      count <= '0;
      channel_state <= icch_pkg::MASK_RESET;
      rise_flags <= icch_pkg::MASK_RESET;
      fall_flags <= icch_pkg::MASK_RESET;
      overflow_flags <= icch_pkg::MASK_RESET;
      match_flags <= icch_pkg::MASK_RESET;
    end else begin
      tick_cnt <= next_tick_cnt;
      deb_cnt <= next_deb_cnt;
      count <= next_count;
      channel_state <= next_channel_state;
      rise_flags <= next_rise_flags;
      fall_flags <= next_fall_flags;
      overflow_flags <= next_overflow_flags;
      match_flags <= next_match_flags;
    end
  end

  assign irq = |rise_flags || |fall_flags ||
               |(overflow_flags & ovf_ie) || |(match_flags & match_ie);

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  sequence s_take;
    cmd_valid && cmd_ready;
  endsequence
  sequence s_exec;
    state == icch_pkg::ST_EXEC;
  endsequence

  reply_after_effect_a: assert property (s_take |=> s_exec ##1
    state == icch_pkg::ST_REPLY ##1 reply_valid)
    else $error("reply not two cycles after execution");
  echo_code_a: assert property (reply_valid |->
    in_mailbox.in_mailbox_byte2 == cmd.out_mailbox_byte2 &&
    in_mailbox.in_mailbox_byte3 == $past(channel_state))
    else $error("echo or input levels wrong");
  rise_load_a: assert property (state == icch_pkg::ST_EXEC &&
    cmd.out_mailbox_byte2 == icch_pkg::CMD_RISE_EN |=>
    rise_en == $past(cmd.out_mailbox_byte0))
    else $error("rising enables not loaded");
  fall_load_a: assert property (state == icch_pkg::ST_EXEC &&
    cmd.out_mailbox_byte2 == icch_pkg::CMD_FALL_EN |=>
    fall_en == $past(cmd.out_mailbox_byte0))
    else $error("falling enables not loaded");
  edge_irq_a: assert property (|(rise_ev & rise_en) |=> irq)
    else $error("enabled rising edge raised no request");
  count_enable_a: assert property (state == icch_pkg::ST_EXEC &&
    cmd.out_mailbox_byte2 == icch_pkg::CMD_CNT_EN |=>
    cnt_en == $past(cmd.out_mailbox_byte0))
    else $error("counter enables not loaded");
  count_reload_a: assert property (cnt_rst_mask[0] |=>
    count[0] == $past(reset_value[0]))
    else $error("counter not reloaded");
  overflow_irq_a: assert property (overflow_flags[2] && ovf_ie[2] |-> irq)
    else $error("enabled overflow raised no request");
  match_load_a: assert property (state == icch_pkg::ST_EXEC &&
    cmd.out_mailbox_byte2 == icch_pkg::CMD_MATCH_IE |=>
    match_ie == $past(cmd.out_mailbox_byte0))
    else $error("match enables not loaded");
  falling_count_a: assert property (cnt_en[1] && cnt_edge[1] &&
    fall_ev[1] && !cnt_rst_mask[1] |=>
    count[1] == $past(count[1]) + icch_pkg::CNT_ONE)
    else $error("falling edge not counted");
  readback_a: assert property (reply_valid &&
    cmd.out_mailbox_byte2 == icch_pkg::CMD_CNT_READ |->
    {in_mailbox.in_mailbox_byte1, in_mailbox.in_mailbox_byte0} ==
    $past(count[read_sel]))
    else $error("readback value wrong");
  high_number_a: assert property (state == icch_pkg::ST_EXEC &&
    is_sample(cmd.out_mailbox_byte2) &&
    cmd.out_mailbox_byte2 <= icch_pkg::CMD_HIGH_LAST |=>
    high_num[cmd.out_mailbox_byte2[2:0]] == $past(param_word))
    else $error("high sampling number not loaded");
  filter_hold_a: assert property (filter_enable[4] &&
    !channel_state[4] && high_num[4] != icch_pkg::SAMPLE_RESET &&
    isolated_input_channel[4] && !tick |=> !channel_state[4])
    else $error("level passed before its period");
  wrap_count_a: assert property (inc_ev[2] && !cnt_rst_mask[2] &&
    count[2] == icch_pkg::CNT_MAX |=>
    count[2] == '0 && overflow_flags[2])
    else $error("counter wrap or overflow flag wrong");

endmodule : icch_input_counter_cmd

`default_nettype wire

/* File: tb/icch_host_model.sv */
// Purpose: host driver model that offers mailbox commands one at a time
// Assumes: called 1 ns after a rising edge; one command in flight
// Notes: mailbox is zero before the first command, inverted junk after each accepted one
`timescale 1ns/1ps
`default_nettype none

module icch_host_model (
  // clock
  input wire logic clk,
  // mailbox
  output icch_pkg::icch_out_mbox_t out_mailbox,
  output logic cmd_valid,
  input wire logic cmd_ready,
  input wire icch_pkg::icch_in_mbox_t in_mailbox,
  input wire logic reply_valid
);
  initial begin
    out_mailbox = 32'h0;
    cmd_valid = 1'b0;
  end

  task automatic send(input logic [7:0] code, input logic [15:0] par,
                      output icch_pkg::icch_in_mbox_t rep, output logic ok);
    int n;
    ok = 1'b0;
    rep = '0;
    out_mailbox = {8'h00, code, par};
    cmd_valid = 1'b1;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (cmd_ready === 1'b1) begin
      @(posedge clk);
      #1;
      cmd_valid = 1'b0;
      // stale bytes must not look like a valid command
      out_mailbox = ~out_mailbox;
      for (n = 0; n < 10 && ok !== 1'b1; n++) begin
        if (reply_valid === 1'b1) begin
          ok = 1'b1;
          rep = in_mailbox;
        end else begin
          @(posedge clk);
          #1;
        end
      end
    end else begin
      cmd_valid = 1'b0;
    end
  endtask : send
endmodule : icch_host_model

`default_nettype wire

/* File: tb/tb.sv */
// Purpose: self-checking bench of the input counter command handler
// Assumes: filter tick shortened to 4 cycles
// Notes: stimulus moves 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none

module tb;
  localparam int TICK = 4;
  logic clk, srst, cmd_valid, cmd_ready, reply_valid, irq;
  icch_pkg::icch_out_mbox_t out_mailbox;
  icch_pkg::icch_in_mbox_t in_mailbox, rep;
  icch_pkg::icch_word_vec_t reset_value, match_value;
  logic [7:0] din, filt, eclr, oclr, mclr, state, rise, fall, ovf, mat;
  logic [7:0] codes [12] = '{8'h23, 8'h24, 8'h28, 8'h29, 8'h2a, 8'h2b,
                             8'h2c, 8'h2f, 8'h30, 8'h37, 8'h38, 8'h3f};
  int err_total;
  int comparisons;

  icch_input_counter_cmd #(.NUM_CH(8), .SAMPLE_CYCLES(TICK))
    icch_input_counter_cmd_inst (.clk(clk), .srst(srst),
    .out_mailbox(out_mailbox), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .in_mailbox(in_mailbox),
    .reply_valid(reply_valid), .isolated_input_channel(din),
    .filter_enable(filt), .reset_value(reset_value),
    .match_value(match_value), .edge_clear(eclr), .overflow_clear(oclr),
    .match_clear(mclr), .channel_state(state), .rise_flags(rise),
    .fall_flags(fall), .overflow_flags(ovf), .match_flags(mat), .irq(irq));

  icch_host_model icch_host_model_inst (.clk(clk), .out_mailbox(out_mailbox),
    .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .in_mailbox(in_mailbox),
    .reply_valid(reply_valid));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic run(input logic [7:0] code, input logic [15:0] par);
    logic ok;
    icch_host_model_inst.send(code, par, rep, ok);
    if (ok !== 1'b1) begin
      err_total++;
      $display("[ERR] reply expected 1 seen 0");
      stop_test();
    end else begin
      chk("echo", rep.in_mailbox_byte2, code);
      chk("levels", rep.in_mailbox_byte3, din);
    end
  endtask : run

  task automatic rd(input logic [2:0] ch, input logic [15:0] exp);
    run(8'h2f, {13'h0, ch});
    chk("count", {rep.in_mailbox_byte1, rep.in_mailbox_byte0}, exp);
  endtask : rd

  task automatic pulse(input logic [7:0] m);
    din = din ^ m;
    cyc(2);
    din = din ^ m;
    cyc(2);
  endtask : pulse

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    srst = 1'b1;
    {din, filt, eclr, oclr, mclr} = 40'h0;
    reset_value = '0;
    // match values kept away from any count reached below
    match_value = {8{16'haaaa}};
    err_total = 0;
    comparisons = 0;
    cyc(16);
    chk("ready", cmd_ready, 16'h1);
    chk("mbox hi", in_mailbox[31:16], 16'h0);
    chk("mbox lo", in_mailbox[15:0], 16'h0);
    chk("edge flags", {rise, fall}, 16'h0);
    chk("cnt flags", {ovf, mat}, 16'h0);
    chk("state irq", {state, 7'h0, irq}, 16'h0);
    srst = 1'b0;
    $display("test reset done");
    din = 8'h81;
    cyc(2);
    chk("state", state, 8'h81);
    foreach (codes[i]) begin
      run(codes[i], 16'h0);
      chk("zero", {rep.in_mailbox_byte1, rep.in_mailbox_byte0}, 16'h0);
    end
    din = 8'h00;
    cyc(2);
    $display("test echo done");
    run(8'h23, 16'h0001);
    run(8'h24, 16'h0002);
    din = 8'h03;
    cyc(2);
    chk("rise", rise, 8'h01);
    chk("fall", fall, 8'h00);
    chk("irq", irq, 16'h1);
    eclr = 8'hff;
    cyc(1);
    eclr = 8'h00;
    din = 8'h00;
    cyc(2);
    chk("fall", fall, 8'h02);
    chk("rise", rise, 8'h00);
    chk("irq", irq, 16'h1);
    eclr = 8'hff;
    cyc(1);
    eclr = 8'h00;
    cyc(1);
    chk("irq", irq, 16'h0);
    run(8'h23, 16'h0000);
    run(8'h24, 16'h0000);
    $display("test edges done");
    run(8'h28, 16'h0003);
    run(8'h2c, 16'h0002);
    din = 8'h07;
    cyc(2);
    rd(3'd0, 16'h0001);
    rd(3'd1, 16'h0000);
    rd(3'd2, 16'h0000);
    din = 8'h00;
    cyc(2);
    rd(3'd0, 16'h0001);
    rd(3'd1, 16'h0001);
    reset_value[0] = 16'h1234;
    reset_value[1] = 16'h5678;
    reset_value[2] = 16'hffff;
    run(8'h29, 16'h0001);
    rd(3'd0, 16'h1234);
    rd(3'd1, 16'h0001);
    $display("test counters done");
    run(8'h28, 16'h000f);
    run(8'h29, 16'h0004);
    rd(3'd2, 16'hffff);
    din = 8'h04;
    cyc(2);
    chk("ovf", ovf, 8'h04);
    chk("irq", irq, 16'h0);
    rd(3'd2, 16'h0000);
    run(8'h2a, 16'h0004);
    chk("irq", irq, 16'h1);
    oclr = 8'hff;
    cyc(1);
    oclr = 8'h00;
    din = 8'h00;
    cyc(1);
    chk("irq", irq, 16'h0);
    match_value[3] = 16'h0002;
    pulse(8'h08);
    pulse(8'h08);
    chk("match", mat, 8'h08);
    chk("irq", irq, 16'h0);
    run(8'h2b, 16'h0008);
    chk("irq", irq, 16'h1);
    mclr = 8'hff;
    cyc(1);
    mclr = 8'h00;
    cyc(1);
    chk("irq", irq, 16'h0);
    $display("test flags done");
    filt = 8'h30;
    run(8'h34, 16'h0003);
    run(8'h3c, 16'h0001);
    run(8'h35, 16'h0100);
    din = 8'h30;
    cyc(TICK);
    din = 8'h00;
    cyc(TICK * 3);
    chk("short", state, 8'h00);
    din = 8'h30;
    cyc(TICK * 2 - 1);
    chk("early", state[4], 16'h0);
    cyc(TICK + 3);
    chk("high", state[4], 16'h1);
    cyc(900);
    chk("slow", state[5], 16'h0);
    cyc(200);
    chk("slow", state[5], 16'h1);
    din = 8'h20;
    cyc(TICK + 2);
    chk("low", state[4], 16'h0);
    $display("test filter done");
    stop_test();
  end
endmodule : tb

`default_nettype wire
